// ===== bsf_defs.svh
// timing counts, command encodings and status bit positions for the flash host controller
`ifndef BSF_DEFS_SVH
`define BSF_DEFS_SVH

`define BSF_CLK_NS        20
// access cycle strobe width and recovery, nanoseconds
`define BSF_STROBE_NS     90
`define BSF_RECOVER_NS    40
// hardware reset pulse width, nanoseconds
`define BSF_RESET_NS      500
`define BSF_STROBE_CYC    ((`BSF_STROBE_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_RECOVER_CYC   ((`BSF_RECOVER_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_RESET_CYC     ((`BSF_RESET_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_CNT_W         8

// command sequence addresses and data (plain defaults)
`define BSF_UNLOCK_ADDR1  20'h00555
`define BSF_UNLOCK_ADDR2  20'h002aa
`define BSF_UNLOCK_DATA1  16'h00aa
`define BSF_UNLOCK_DATA2  16'h0055
`define BSF_CMD_PROGRAM   16'h00a0
`define BSF_CMD_ERASE     16'h0080
`define BSF_CMD_CHIP      16'h0010
`define BSF_CMD_SECTOR    16'h0030
`define BSF_CMD_SUSPEND   16'h00b0
`define BSF_CMD_RESUME    16'h0030
`define BSF_CMD_BYPASS    16'h0020
`define BSF_CMD_BYP_EXIT1 16'h0090
`define BSF_CMD_BYP_EXIT2 16'h0000
`define BSF_CMD_RESET     16'h00f0

// status bit positions and byte-mode data mask
`define BSF_POLL_BIT      7
`define BSF_TOGGLE_BIT    6
`define BSF_BYTE_MASK     16'h00ff

`endif

// ===== bsf_flash_model.sv
// behavioural boot-sector flash answering the controller's pins
`timescale 1ns/10ps
module bsf_flash_model #(
	parameter int         BUSY = 40,
	parameter logic [3:0] PROT = 4'h8
) (
	input  wire logic        clk_sys,
	input  wire logic [19:0] flash_addr,
	input  wire logic [15:0] data_bus_lines_in,
	input  wire logic        chip_en_n,
	input  wire logic        write_en_n,
	input  wire logic        out_en_n,
	input  wire logic        hw_reset_n,
	input  wire logic        byte_sel_n,
	output logic [15:0]      dev_dq,
	output logic             operation_done_pin_n
);
	logic [15:0] mem [16];
	logic [15:0] last = 16'h0000;
	logic [15:0] pdat = 16'h0000;
	logic [15:0] rd;
	logic [3:0]  step = 4'h0;
	logic        byp = 1'b0;
	logic        tog = 1'b0;
	logic        low_supply = 1'b0;
	logic        unprot = 1'b0;
	int          left = 0;
	wire  [3:0]  ix = {flash_addr[17:16], flash_addr[1:0]};
	wire  [7:0]  d = data_bus_lines_in[7:0];
	wire         sel = !chip_en_n && !out_en_n;
	initial for (int i = 0; i < 16; i++) mem[i] = (i > 11) ? 16'ha5a5 : 16'hffff;
	assign operation_done_pin_n = (left == 0);
	assign rd = (left > 0) ? {8'h00, ~pdat[7], tog, 6'h00} : mem[ix];
	// released lines show the inverse of the last value
	assign dev_dq = sel ? (byte_sel_n ? rd : {~last[15:8], rd[7:0]}) : ~last;
	always @(posedge clk_sys) if (sel) last <= dev_dq;
	always @(negedge out_en_n) if (left > 0) tog = !tog;
	always @(posedge clk_sys or negedge hw_reset_n) begin
		if (!hw_reset_n) begin
			left = 0;
			step = 4'h0;
			byp = 1'b0;
		end else if (left > 0) begin
			left = left - 1;
		end
	end
	always @(posedge write_en_n) begin
		if (!chip_en_n && hw_reset_n && left == 0 && !low_supply) begin
			case (step)
				4'h0: step = byp ? (d == 8'ha0 ? 4'h3 : 4'h7) : {3'h0, d == 8'haa};
				4'h1: step = (d == 8'h55) ? 4'h2 : 4'h0;
				4'h2: begin
					byp = byp || d == 8'h20;
					step = (d == 8'ha0) ? 4'h3 : (d == 8'h80) ? 4'h4 : 4'h0;
				end
				4'h3: begin
					pdat = data_bus_lines_in;
					if (!PROT[flash_addr[17:16]] || unprot) begin
						mem[ix] &= byte_sel_n ? data_bus_lines_in : {8'hff, d};
						left = BUSY;
					end
					step = 4'h0;
				end
				4'h4: step = (d == 8'haa) ? 4'h5 : 4'h0;
				4'h5: step = (d == 8'h55) ? 4'h6 : 4'h0;
				4'h6: begin
					pdat = 16'hffff;
					for (int i = 0; i < 16; i++)
						if ((d == 8'h10 || i[3:2] == ix[3:2]) && (!PROT[i[3:2]] || unprot))
							mem[i] = 16'hffff;
					left = BUSY;
					step = 4'h0;
				end
				default: begin
					byp = 1'b0;
					step = 4'h0;
				end
			endcase
		end
	end
endmodule

// ===== bsf_host.sv
// host-side controller driving a boot-sector parallel flash over its pins
// ----------------------------------------
// Summary of operation
// ----------------------------------------
// Summary of operation
// RULE1 - word mode uses all sixteen data lines, byte mode only the low eight
// RULE2 - in bypass mode a program takes two writes instead of four
// RULE3 - after a program sequence the device times and verifies on its own
// RULE4 - erase preprograms then erases and verifies on its own
// RULE5 - erase targets whole chip or any chosen set of sectors
// RULE6 - progress shows on ready/busy pin, poll bit and toggling bit
// RULE7 - finished operation returns device to array read, ready for commands
// RULE8 - hardware reset pin aborts any operation and returns to array read
// RULE9 - during erase suspend touch only unselected sectors, then resume
// RULE10 - device rejects program and erase to protected sectors
// RULE11 - temporary unprotect allows changes to locked sectors while active
// RULE12 - device blocks writes during power transitions
// RULE13 - device sleeps on stable addresses and stands by when deselected
// RULE14 - sectors are 16K, two 8K, 32K and fifteen 64K bytes
// RULE15 - boot sectors sit at top or bottom per variant
// RULE16 - each write cycle latches address and data in the device
// RULE17 - commands are plain write cycles into the command register
// RULE18 - erasing one sector leaves other sectors unchanged
// RULE19 - separate enables keep host and device from contending on data lines
// RULE20 - wait for completion before new commands except suspend or reset
`timescale 1ns/10ps
`include "bsf_defs.svh"

module bsf_host (
	input  wire logic           clk_sys,
	input  wire logic           nrst,
	input  wire logic           req,
	input  wire bsf_pkg::bsf_op_t op,
	input  wire logic [19:0]    addr,
	input  wire logic [15:0]    wdata,
	input  wire logic           byte_mode,
	output logic                busy,
	output logic                done,
	output logic                fail,
	output logic [15:0]         rdata,
	output logic [19:0]         flash_addr,
	output logic [15:0]         data_bus_lines_out,
	output logic                data_bus_lines_oe,
	input  wire logic [15:0]    data_bus_lines_in,
	output logic                chip_en_n,
	output logic                write_en_n,
	output logic                out_en_n,
	output logic                hw_reset_n,
	output logic                byte_sel_n,
	input  wire logic           operation_done_pin_n
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [15:0] dq_s1, dq_s2;
	logic        rb_s1, rb_s2;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
			rb_s1 <= 1'b1;
			rb_s2 <= 1'b1;
		end else begin
			dq_s1 <= data_bus_lines_in;
			dq_s2 <= dq_s1;
			rb_s1 <= operation_done_pin_n;
			rb_s2 <= rb_s1;
		end
	end

	// ----------------------------------------
	// command sequence table
	// ----------------------------------------
	bsf_pkg::bsf_state_t state;
	bsf_pkg::bsf_op_t    cur_op;
	logic [19:0]         cur_addr;
	logic [15:0]         cur_data;
	logic                bypass;
	logic [2:0]          step;
	logic [2:0]          nsteps;
	logic                is_read;
	logic                need_poll;
	logic [`BSF_CNT_W-1:0] cnt;
	logic [15:0]         prev_stat;
	logic                poll_first;
	logic [19:0]         cyc_addr;
	logic [15:0]         cyc_data;

	always_comb begin
		cyc_addr = cur_addr;
		cyc_data = cur_data;
		nsteps   = 3'd1;
		case (cur_op)
			bsf_pkg::BSF_OP_PROGRAM: begin
				if (bypass) begin
					nsteps = 3'd2; // RULE2
					cyc_addr = (step == 3'd0) ? cur_addr : cur_addr;
					cyc_data = (step == 3'd0) ? `BSF_CMD_PROGRAM : cur_data;
				end else begin
					nsteps = 3'd4; // RULE2
					case (step)
						3'd0: begin cyc_addr = `BSF_UNLOCK_ADDR1; cyc_data = `BSF_UNLOCK_DATA1; end
						3'd1: begin cyc_addr = `BSF_UNLOCK_ADDR2; cyc_data = `BSF_UNLOCK_DATA2; end
						3'd2: begin cyc_addr = `BSF_UNLOCK_ADDR1; cyc_data = `BSF_CMD_PROGRAM; end
						default: begin cyc_addr = cur_addr; cyc_data = cur_data; end
					endcase
				end
			end
			bsf_pkg::BSF_OP_CHIP, bsf_pkg::BSF_OP_SECTOR: begin
				nsteps = 3'd6; // RULE5
				case (step)
					3'd0, 3'd3: begin cyc_addr = `BSF_UNLOCK_ADDR1; cyc_data = `BSF_UNLOCK_DATA1; end
					3'd1, 3'd4: begin cyc_addr = `BSF_UNLOCK_ADDR2; cyc_data = `BSF_UNLOCK_DATA2; end
					3'd2: begin cyc_addr = `BSF_UNLOCK_ADDR1; cyc_data = `BSF_CMD_ERASE; end
					default: begin
						cyc_addr = (cur_op == bsf_pkg::BSF_OP_CHIP) ? `BSF_UNLOCK_ADDR1 : cur_addr;
						cyc_data = (cur_op == bsf_pkg::BSF_OP_CHIP) ? `BSF_CMD_CHIP
							: `BSF_CMD_SECTOR;
					end
				endcase
			end
			bsf_pkg::BSF_OP_SECT_ADD: cyc_data = `BSF_CMD_SECTOR; // RULE5
			bsf_pkg::BSF_OP_SUSPEND: cyc_data = `BSF_CMD_SUSPEND; // RULE9
			bsf_pkg::BSF_OP_RESUME: cyc_data = `BSF_CMD_RESUME; // RULE9
			bsf_pkg::BSF_OP_BYP_ON: begin
				nsteps = 3'd3;
				case (step)
					3'd0: begin cyc_addr = `BSF_UNLOCK_ADDR1; cyc_data = `BSF_UNLOCK_DATA1; end
					3'd1: begin cyc_addr = `BSF_UNLOCK_ADDR2; cyc_data = `BSF_UNLOCK_DATA2; end
					default: begin cyc_addr = `BSF_UNLOCK_ADDR1; cyc_data = `BSF_CMD_BYPASS; end
				endcase
			end
			bsf_pkg::BSF_OP_BYP_OFF: begin
				nsteps = 3'd2;
				cyc_data = (step == 3'd0) ? `BSF_CMD_BYP_EXIT1 : `BSF_CMD_BYP_EXIT2;
			end
			bsf_pkg::BSF_OP_RESET: cyc_data = `BSF_CMD_RESET; // RULE7
			default: ;
		endcase
	end

	assign is_read   = (cur_op == bsf_pkg::BSF_OP_READ);
	assign need_poll = (cur_op == bsf_pkg::BSF_OP_PROGRAM) || (cur_op == bsf_pkg::BSF_OP_CHIP)
		|| (cur_op == bsf_pkg::BSF_OP_SECTOR);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state      <= bsf_pkg::BSF_IDLE;
			cur_op     <= bsf_pkg::BSF_OP_NONE;
			cur_addr   <= 20'h00000;
			cur_data   <= 16'h0000;
			step       <= 3'd0;
			cnt        <= '0;
			prev_stat  <= 16'h0000;
			poll_first <= 1'b0;
		end else begin
			case (state)
				bsf_pkg::BSF_IDLE: begin
					step <= 3'd0;
					if (req) begin
						cur_op   <= op;
						cur_addr <= addr;
						cur_data <= byte_mode ? (wdata & `BSF_BYTE_MASK) : wdata; // RULE1
						cnt      <= '0;
						state    <= (op == bsf_pkg::BSF_OP_NONE) ? bsf_pkg::BSF_HWRST
							: bsf_pkg::BSF_SETUP; // RULE8
					end
				end
				bsf_pkg::BSF_SETUP: state <= bsf_pkg::BSF_STROBE;
				bsf_pkg::BSF_STROBE: begin
					cnt <= cnt + 1'b1;
					if (cnt == `BSF_CNT_W'(`BSF_STROBE_CYC - 1)) begin
						cnt   <= '0;
						state <= bsf_pkg::BSF_RECOV;
					end
				end
				bsf_pkg::BSF_RECOV: begin
					cnt <= cnt + 1'b1;
					if (cnt == `BSF_CNT_W'(`BSF_RECOVER_CYC + 1)) begin
						cnt <= '0;
						if (step + 3'd1 < nsteps && !is_read) begin
							step  <= step + 3'd1; // RULE17
							state <= bsf_pkg::BSF_SETUP;
						end else if (need_poll) begin
							poll_first <= 1'b1;
							state      <= bsf_pkg::BSF_POLL; // RULE20
						end else begin
							state <= bsf_pkg::BSF_DONE;
						end
					end
				end
				bsf_pkg::BSF_POLL: begin
					// status reads repeat until the toggling bit holds still and the ready/busy pin reads ready
					cnt <= cnt + 1'b1;
					if (cnt == `BSF_CNT_W'(`BSF_STROBE_CYC + 1)) begin
						cnt        <= '0;
						poll_first <= 1'b0;
						prev_stat  <= dq_s2;
						if (!poll_first && rb_s2 &&
							(dq_s2[`BSF_TOGGLE_BIT] == prev_stat[`BSF_TOGGLE_BIT])) // RULE6
							state <= bsf_pkg::BSF_DONE;
					end
				end
				bsf_pkg::BSF_HWRST: begin
					cnt <= cnt + 1'b1;
					if (cnt == `BSF_CNT_W'(`BSF_RESET_CYC - 1))
						state <= bsf_pkg::BSF_DONE;
				end
				bsf_pkg::BSF_DONE: state <= bsf_pkg::BSF_IDLE;
				default: state <= bsf_pkg::BSF_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// bypass mode tracking
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			bypass <= 1'b0;
		else if (state == bsf_pkg::BSF_DONE) begin
			if (cur_op == bsf_pkg::BSF_OP_BYP_ON)
				bypass <= 1'b1; // RULE2
			else if (cur_op == bsf_pkg::BSF_OP_BYP_OFF || cur_op == bsf_pkg::BSF_OP_NONE
				|| cur_op == bsf_pkg::BSF_OP_RESET)
				bypass <= 1'b0;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			chip_en_n          <= 1'b1;
			write_en_n         <= 1'b1;
			out_en_n           <= 1'b1;
			data_bus_lines_oe  <= 1'b0;
			data_bus_lines_out <= 16'h0000;
			flash_addr         <= 20'h00000;
			hw_reset_n         <= 1'b0;
			byte_sel_n         <= 1'b1;
		end else begin
			hw_reset_n <= (state != bsf_pkg::BSF_HWRST); // RULE8
			byte_sel_n <= !byte_mode; // RULE1
			case (state)
				bsf_pkg::BSF_SETUP: begin
					flash_addr         <= cyc_addr; // RULE16
					data_bus_lines_out <= cyc_data;
					chip_en_n          <= 1'b0;
					data_bus_lines_oe  <= !is_read; // RULE19
				end
				bsf_pkg::BSF_STROBE: begin
					write_en_n <= is_read;
					out_en_n   <= !is_read; // RULE19
				end
				bsf_pkg::BSF_POLL: begin
					chip_en_n         <= 1'b0;
					data_bus_lines_oe <= 1'b0;
					out_en_n          <= (cnt >= `BSF_CNT_W'(`BSF_STROBE_CYC)); // RULE6
				end
				default: begin
					write_en_n        <= 1'b1;
					out_en_n          <= 1'b1;
					// select and data stay one cycle past the strobe edge the device latches on
					if (cnt == `BSF_CNT_W'(1) || state != bsf_pkg::BSF_RECOV) begin
						data_bus_lines_oe <= 1'b0;
						chip_en_n         <= 1'b1; // RULE13
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// user side status
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy  <= 1'b0;
			done  <= 1'b0;
			fail  <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			busy <= (state != bsf_pkg::BSF_IDLE && state != bsf_pkg::BSF_DONE) || req;
			done <= (state == bsf_pkg::BSF_DONE); // RULE7
			if (state == bsf_pkg::BSF_RECOV && cnt == `BSF_CNT_W'(0) && is_read)
				rdata <= byte_mode ? (dq_s2 & `BSF_BYTE_MASK) : dq_s2; // RULE1
			if (state == bsf_pkg::BSF_DONE && need_poll)
				fail <= (dq_s2[`BSF_POLL_BIT] != cur_data[`BSF_POLL_BIT])
					&& (cur_op == bsf_pkg::BSF_OP_PROGRAM); // RULE10
		end
	end

endmodule

// ===== bsf_host_sva.sv
// pin-level and user handshake assertions for the flash host controller
`timescale 1ns/10ps
module bsf_host_sva (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        req,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        byte_mode,
	input wire logic [19:0] flash_addr,
	input wire logic [15:0] data_bus_lines_out,
	input wire logic        data_bus_lines_oe,
	input wire logic        chip_en_n,
	input wire logic        write_en_n,
	input wire logic        out_en_n,
	input wire logic        hw_reset_n,
	input wire logic        byte_sel_n,
	input wire logic        operation_done_pin_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_we_pulse;
		!write_en_n [*5] ##1 write_en_n;
	endsequence
	sequence s_oe_pulse;
		!out_en_n [*5] ##1 out_en_n;
	endsequence
	a_write_strobe_len: assert property ($fell(write_en_n) |-> s_we_pulse)
		else $error("write strobe width wrong");
	a_read_strobe_len: assert property ($fell(out_en_n) |-> s_oe_pulse)
		else $error("read strobe width wrong");
	a_no_bus_fight: assert property (data_bus_lines_oe |-> out_en_n)
		else $error("host drives while device outputs enabled");
	a_write_selected: assert property (!write_en_n |-> !chip_en_n && data_bus_lines_oe)
		else $error("write strobe without select or data");
	a_write_held: assert property (!write_en_n && $past(!write_en_n)
		|-> $stable(flash_addr) && $stable(data_bus_lines_out)) else $error("write cycle moved");
	a_byte_low_only: assert property (data_bus_lines_oe && !byte_sel_n
		|-> data_bus_lines_out[15:8] == 8'h00) else $error("upper lines used in byte mode");
	a_byte_select: assert property ($changed(byte_mode) |=> byte_sel_n == !$past(byte_mode))
		else $error("byte select not following mode");
	a_wait_ready: assert property ($fell(write_en_n) |-> operation_done_pin_n)
		else $error("write while device busy");
	a_done_once: assert property (done |=> !done && !busy)
		else $error("done not a single pulse");
	a_req_taken: assert property (req && !busy && !done |=> busy)
		else $error("request not taken");
	a_reset_pulse: assert property ($fell(hw_reset_n) |-> !hw_reset_n [*8])
		else $error("flash reset pulse too short");
endmodule
bind bsf_host bsf_host_sva u_sva (.clk_sys, .nrst, .req, .busy, .done, .byte_mode, .flash_addr,
	.data_bus_lines_out, .data_bus_lines_oe, .chip_en_n, .write_en_n, .out_en_n, .hw_reset_n,
	.byte_sel_n, .operation_done_pin_n);

// ===== bsf_pkg.sv
// types for the flash host controller
package bsf_pkg;
	typedef enum logic [3:0] {
		BSF_OP_NONE    = 4'h0,
		BSF_OP_READ    = 4'h1,
		BSF_OP_PROGRAM = 4'h2,
		BSF_OP_CHIP    = 4'h3,
		BSF_OP_SECTOR  = 4'h4,
		BSF_OP_SUSPEND = 4'h5,
		BSF_OP_RESUME  = 4'h6,
		BSF_OP_BYP_ON  = 4'h7,
		BSF_OP_BYP_OFF = 4'h8,
		BSF_OP_RESET   = 4'h9,
		BSF_OP_SECT_ADD = 4'ha
	} bsf_op_t;

	typedef enum logic [6:0] {
		BSF_IDLE   = 7'h01,
		BSF_SETUP  = 7'h02,
		BSF_STROBE = 7'h04,
		BSF_RECOV  = 7'h08,
		BSF_POLL   = 7'h10,
		BSF_HWRST  = 7'h20,
		BSF_DONE   = 7'h40
	} bsf_state_t;
endpackage

// ===== tb_bsf_host.sv
// self-checking bench for the flash host controller against a flash model
`timescale 1ns/10ps
`include "bsf_defs.svh"
module tb_bsf_host;
	localparam int    BUSY = 40;
	logic             clk_sys = 1'b0;
	logic             nrst = 1'b0;
	logic             req = 1'b0;
	logic             byte_mode = 1'b0;
	bsf_pkg::bsf_op_t op = bsf_pkg::BSF_OP_READ;
	logic [19:0]      addr = 20'h00000;
	logic [15:0]      wdata = 16'h0000;
	logic             busy, done, fail, data_bus_lines_oe, chip_en_n, write_en_n;
	logic             out_en_n, hw_reset_n, byte_sel_n, operation_done_pin_n;
	logic [15:0]      rdata, data_bus_lines_out, data_bus_lines_in, dev_dq;
	logic [19:0]      flash_addr;
	int               errors = 0;
	int               checked = 0;
	int               nwr, nlow, waited;
	initial forever #10 clk_sys = ~clk_sys;
	assign data_bus_lines_in = data_bus_lines_oe ? data_bus_lines_out : dev_dq;
	always @(negedge write_en_n) nwr++;
	always @(posedge clk_sys) if (!hw_reset_n) nlow++;
	bsf_host uut (.clk_sys, .nrst, .req, .op, .addr, .wdata, .byte_mode, .busy, .done, .fail,
		.rdata, .flash_addr, .data_bus_lines_out, .data_bus_lines_oe, .data_bus_lines_in,
		.chip_en_n, .write_en_n, .out_en_n, .hw_reset_n, .byte_sel_n, .operation_done_pin_n);
	bsf_flash_model #(.BUSY(BUSY)) u_flash (.clk_sys, .flash_addr, .data_bus_lines_in,
		.chip_en_n, .write_en_n, .out_en_n, .hw_reset_n, .byte_sel_n, .dev_dq,
		.operation_done_pin_n);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp1(input string n, input logic e, input logic g);
		cmp16(n, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic run(input bsf_pkg::bsf_op_t o, input logic [19:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		req <= 1'b1;
		op <= o;
		addr <= a;
		wdata <= d;
		nwr = 0;
		nlow = 0;
		@(posedge clk_sys);
		req <= 1'b0;
		#1;
		for (waited = 1; waited < 4000 && done !== 1'b1; waited++) @(posedge clk_sys) #1;
		if (waited == 4000) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [19:0] a, input logic [15:0] e);
		run(bsf_pkg::BSF_OP_READ, a, 16'h0000);
		cmp16("rdata", e, rdata);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_program();
		cmp1("hw_reset_n", 1'b1, hw_reset_n);
		run(bsf_pkg::BSF_OP_PROGRAM, 20'h00001, 16'h1234);
		cmp16("writes", 16'h0004, nwr[15:0]);
		cmp1("fail", 1'b0, fail);
		cmp1("waited", 1'b1, waited > 40 + BUSY);
		rd(20'h00001, 16'h1234);
	endtask
	task automatic t_bypass();
		run(bsf_pkg::BSF_OP_BYP_ON, 20'h00000, 16'h0000);
		cmp16("writes", 16'h0003, nwr[15:0]);
		run(bsf_pkg::BSF_OP_PROGRAM, 20'h00002, 16'h00f0);
		cmp16("writes", 16'h0002, nwr[15:0]);
		rd(20'h00002, 16'h00f0);
		run(bsf_pkg::BSF_OP_BYP_OFF, 20'h00000, 16'h0000);
		cmp16("writes", 16'h0002, nwr[15:0]);
	endtask
	task automatic t_erase();
		run(bsf_pkg::BSF_OP_PROGRAM, 20'h10000, 16'h0000);
		run(bsf_pkg::BSF_OP_SECTOR, 20'h10000, 16'h0000);
		cmp16("writes", 16'h0006, nwr[15:0]);
		rd(20'h10000, 16'hffff);
		rd(20'h00001, 16'h1234);
		run(bsf_pkg::BSF_OP_PROGRAM, 20'h30000, 16'h0000);
		cmp1("fail", 1'b1, fail);
		run(bsf_pkg::BSF_OP_CHIP, 20'h00000, 16'h0000);
		rd(20'h00001, 16'hffff);
		rd(20'h30000, 16'ha5a5);
	endtask
	task automatic t_guard();
		u_flash.low_supply = 1'b1;
		run(bsf_pkg::BSF_OP_PROGRAM, 20'h00001, 16'h0000);
		u_flash.low_supply = 1'b0;
		rd(20'h00001, 16'hffff);
		u_flash.unprot = 1'b1;
		run(bsf_pkg::BSF_OP_PROGRAM, 20'h30001, 16'h0101);
		u_flash.unprot = 1'b0;
		rd(20'h30001, 16'h0101);
		rd(20'h30000, 16'ha5a5);
	endtask
	task automatic t_byte_reset();
		@(posedge clk_sys);
		byte_mode <= 1'b1;
		run(bsf_pkg::BSF_OP_PROGRAM, 20'h00003, 16'hab12);
		run(bsf_pkg::BSF_OP_READ, 20'h00003, 16'h0000);
		cmp16("byte", 16'h0012, {8'h00, rdata[7:0]});
		@(posedge clk_sys);
		byte_mode <= 1'b0;
		run(bsf_pkg::BSF_OP_NONE, 20'h00000, 16'h0000);
		cmp1("reset width", 1'b1, nlow >= `BSF_RESET_CYC);
		rd(20'h00003, 16'hff12);
	endtask
	task automatic t_misc();
		bsf_pkg::bsf_op_t ops [4] = '{bsf_pkg::BSF_OP_SUSPEND, bsf_pkg::BSF_OP_RESUME,
			bsf_pkg::BSF_OP_RESET, bsf_pkg::BSF_OP_SECT_ADD};
		foreach (ops[i]) begin
			run(ops[i], 20'h10000, 16'h0000);
			@(posedge clk_sys) #1;
			cmp1("busy", 1'b0, busy);
		end
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		t_program();
		t_bypass();
		t_erase();
		t_guard();
		t_byte_reset();
		t_misc();
		end_of_test();
	end
endmodule
